// ===== tb/tb_top.sv
// testbench for one channel acting as channel a, and as another channel for one gang-load check
// assumes gang and device reset outputs loop back to its own inputs
`timescale 1ns/100ps
module tb_top
  import ucc_pkg::*;
;
  logic ref_clk = 1'b0, nrst = 1'b0, avs_read = 1'b0, avs_write = 1'b0, is_channel_a = 1'b1;
  logic [2:0] avs_address = 3'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic avs_waitrequest, dev_rst, rx_push, rxd, edge1x, tx_char_valid, tx_take, tx_done;
  logic aux_pin_one, aux_pin_two, timeout_mode, block_err_mode, send_resume, host_stop, break_change;
  logic [3:0] dly = 4'h2;
  logic [7:0] q, tx_char_w;
  logic send_stop, addr_clr;
  ucc_gang_s gang;
  ucc_rx_char_s rx_char;
  int errors = 0, n_tests = 0;
  wire [7:0] lv = {send_stop, addr_clr, aux_pin_one, aux_pin_two, timeout_mode, block_err_mode, send_resume,
    host_stop};
  logic [12:0] tab [13] = '{{CMD_RTS_ON, 8'h10}, {CMD_TMO_ON, 8'h18}, {CMD_BLOCK_ERR, 8'h1c},
    {CMD_SEND_RESUME, 8'h1e}, {CMD_SEND_STOP, 8'h9e}, {CMD_HOST_STOP, 8'h9f}, {5'h01, 8'h9f},
    {CMD_CANCEL_FLOW, 8'h1d}, {CMD_HOST_RESUME, 8'h1c}, {CMD_TMO_OFF, 8'h14}, {CMD_RTS_OFF, 8'h34},
    {5'h0b, 8'h34}, {CMD_RST_ADDR, 8'h74}};
  always #2 ref_clk = ~ref_clk;
  ucc_channel dut_u (.ref_clk, .nrst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .is_channel_a, .chip_reset_in(dev_rst), .gang_in(gang), .gang_out(gang),
    .device_reset_req(dev_rst), .rx_push, .rx_char, .rxd, .rx_clk1x_edge(edge1x), .tx_char(tx_char_w),
    .tx_char_valid, .tx_take, .tx_done, .tx_flow_taken(1'b0), .tx_break(), .aux_pin_one, .aux_pin_two,
    .timeout_mode, .block_err_mode, .send_resume, .send_stop, .host_stop, .addr_recog_clear(addr_clr),
    .break_change);
  ucc_far_model far_u (.ref_clk, .tx_char_valid, .dly, .tx_take, .tx_done, .rx_push, .rx_char, .rxd,
    .edge1x);
  task report_and_stop();
    $display("tests %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task bus(input logic w, input logic [2:0] a, input logic [7:0] d);
    int i;
    @(posedge ref_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {24'h0, d};
    i = 0;
    do begin
      @(posedge ref_clk);
      i++;
    end while (avs_waitrequest !== 1'b0 && i < 20);
    q = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (i >= 20) begin
      errors++;
      report_and_stop();
    end
    @(negedge ref_clk);
  endtask
  task cmd(input logic [4:0] c);
    bus(1'b1, REG_CMD, {c, 3'h0});
  endtask
  task rd(input logic [2:0] a);
    bus(1'b0, a, 8'h00);
  endtask
  task t_cmds();
    rd(REG_STATUS);
    chk(q, 8'h00);
    bus(1'b1, REG_CONFIG, 8'h10);
    foreach (tab[i]) begin
      cmd(tab[i][12:8]);
      chk(lv, tab[i][7:0]);
    end
  endtask
  task t_gang();
    cmd(CMD_GLD_RESUME);
    rd(REG_RESUME);
    chk(q, 8'h11);
    cmd(CMD_GLD_STOP);
    rd(REG_STOP);
    chk(q, 8'h13);
    cmd(CMD_RST_DEV);
    rd(REG_RESUME);
    chk(q, 8'h00);
    chk(lv, 8'h30);
    @(posedge ref_clk);
    is_channel_a <= 1'b0;
    cmd(CMD_GLD_RESUME);
    rd(REG_RESUME);
    chk(q, 8'h00);
    @(posedge ref_clk);
    is_channel_a <= 1'b1;
  endtask
  task t_tx();
    bus(1'b1, REG_TXDATA, 8'h3c);
    bus(1'b1, REG_CONFIG, 8'h02);
    rd(REG_STATUS);
    chk(q & 8'h04, 8'h04);
    chk({7'h0, tx_char_valid}, 8'h00);
    @(posedge ref_clk);
    dly <= 4'h9;
    bus(1'b1, REG_TXDATA, 8'ha5);
    chk(tx_char_w, 8'ha5);
    bus(1'b1, REG_TXDATA, 8'h5a);
    rd(REG_STATUS);
    chk(q & 8'h0c, 8'h00);
    for (int i = 0; i < 20 && q !== 8'h0c; i++)
      rd(REG_STATUS);
    chk(q, 8'h0c);
    bus(1'b1, REG_CONFIG, 8'h00);
    rd(REG_STATUS);
    chk(q, 8'h00);
  endtask
  task t_rx();
    bus(1'b1, REG_CONFIG, 8'h01);
    for (int i = 0; i < 18; i++)
      far_u.send(i[7:0], 1'b1);
    rd(REG_STATUS);
    chk(q, 8'h13);
    rd(REG_RXDATA);
    chk(q, 8'h00);
    rd(REG_STATUS);
    chk(q, 8'h13);
    rd(REG_RXDATA);
    rd(REG_STATUS);
    chk(q, 8'h11);
    cmd(CMD_RST_ERR);
    rd(REG_STATUS);
    chk(q, 8'h01);
    repeat (15) rd(REG_RXDATA);
    chk(q, 8'h11);
    rd(REG_STATUS);
    chk(q, 8'h00);
  endtask
  task t_err();
    far_u.send(8'h55, 1'b0);
    rd(REG_STATUS);
    chk(q, 8'h41);
    rd(REG_RXDATA);
    cmd(CMD_RST_ERR);
    far_u.brk();
    rd(REG_STATUS);
    chk(q & 8'h81, 8'h81);
    chk({7'h0, break_change}, 8'h01);
    cmd(CMD_RST_BRKCHG);
    chk({7'h0, break_change}, 8'h00);
    far_u.send(8'h66, 1'b1);
    far_u.marks();
    rd(REG_STATUS);
    chk({7'h0, break_change}, 8'h01);
    rd(REG_RXDATA);
    rd(REG_STATUS);
    chk(q & 8'h01, 8'h00);
  endtask
  initial begin
    repeat (20) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (5) @(posedge ref_clk);
    t_cmds();
    t_gang();
    t_tx();
    t_rx();
    t_err();
    report_and_stop();
  end
endmodule

// ===== tb/ucc_far_model.sv
// far-side model: remote serial partner of one channel
// assumes its tasks are entered right after a falling edge of ref_clk
`timescale 1ns/100ps
module ucc_far_model
  import ucc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic tx_char_valid,
  input wire logic [3:0] dly,
  output logic tx_take,
  output logic tx_done,
  output logic rx_push,
  output ucc_rx_char_s rx_char,
  output logic rxd,
  output logic edge1x
);
  logic busy;
  logic [3:0] cnt;
  initial begin
    {tx_take, tx_done, rx_push, edge1x, busy, cnt} = 9'h0;
    rx_char = 11'h0;
    rxd = 1'b1;
  end
  // transmitter takes one char at a time and ends it dly+1 cycles after the take
  always @(posedge ref_clk) begin
    tx_take <= 1'b0;
    tx_done <= 1'b0;
    if (busy) begin
      cnt <= cnt + 4'h1;
      busy <= cnt != dly;
      tx_done <= cnt == dly;
    end else if (tx_char_valid && !tx_take) begin
      tx_take <= 1'b1;
      busy <= 1'b1;
      cnt <= 4'h0;
    end
  end
  task send(input logic [7:0] d, input logic ok);
    @(posedge ref_clk);
    rx_push <= 1'b1;
    rx_char <= {d, ok, 2'b10};
    @(posedge ref_clk);
    rx_push <= 1'b0;
    rx_char <= ~{d, ok, 2'b10};
  endtask
  task brk();
    rxd <= 1'b0;
    send(8'h00, 1'b0);
  endtask
  // line back to marking, then two 1x edges
  task marks();
    rxd <= 1'b1;
    repeat (4) @(posedge ref_clk);
    repeat (2) begin
      edge1x <= 1'b1;
      @(posedge ref_clk);
      edge1x <= 1'b0;
      @(posedge ref_clk);
    end
  endtask
endmodule

// ===== verilog/ucc_channel.sv
// one uart channel: command decoder, status register, rx/tx queues
// assumes receiver, transmitter and gang partners run on ref_clk
//
// How it works
// - command is bits 7:3; 00000 nothing, 00010 resets receiver, 00011 transmitter
// - gang and device-reset codes decoded only in channel a
// - 00100 clears errors, 00101 clears break change, 00110/00111 start/stop break
// - 01000 drives request_to_send_n low, 01001 high, on aux pin two or one
// - 01010 turns time-out mode on, 01100 off
// - 01101 accumulates block error status at push time
// - send resume/stop chars, cancel pending one, host stop and resume
// - channel a arms gang writes and gang-loads resume/stop registers
// - 11011 clears address status, 11110 clears registers, 11111 resets device
// - status bits: break, framing, parity, overrun, tx empty, tx ready, rx full, rx ready
// - break takes one entry; entries blocked until two marking 1x edges
// - break change flag set at break start and at break end
// - mid-character break counts only once a whole zero character arrives
// - missing stop bit at its middle sample marks a framing fault
// - parity fault from wrong parity, or address bit in wake-up mode
// - overrun on arrival with queue full and hold busy; old hold lost
// - tx empty set after last stop with empty queue; cleared on load or disable
// - tx ready clears on load, sets when last char moves to shifter
// - tx ready low while disabled, set on enable; disabled loads dropped
// - rx full set when queue fills, clears when a read frees one
// - with a held char, rx full survives the first read
// - rx ready set on push, clears when a read empties the queue
// - reset-error command clears the four error bits together
// - gang load writes 11 and 13 hex into resume and stop registers
//
// Added by the designer: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/100ps
module ucc_channel
  import ucc_pkg::*;
#(
  parameter int RX_DEPTH = 16,
  parameter int TX_DEPTH = 16
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [2:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic is_channel_a,
  input wire logic chip_reset_in,
  input wire ucc_gang_s gang_in,
  output ucc_gang_s gang_out,
  output logic device_reset_req,
  input wire logic rx_push,
  input wire ucc_rx_char_s rx_char,
  input wire logic rxd,
  input wire logic rx_clk1x_edge,
  output logic [7:0] tx_char,
  output logic tx_char_valid,
  input wire logic tx_take,
  input wire logic tx_done,
  input wire logic tx_flow_taken,
  output logic tx_break,
  output logic aux_pin_one,
  output logic aux_pin_two,
  output logic timeout_mode,
  output logic block_err_mode,
  output logic send_resume,
  output logic send_stop,
  output logic host_stop,
  output logic addr_recog_clear,
  output logic break_change
);
  localparam int RAW = $clog2(RX_DEPTH);
  localparam int TAW = $clog2(TX_DEPTH);
  localparam logic [RAW:0] RX_FULL_CNT = (RAW+1)'(RX_DEPTH);
  localparam logic [TAW:0] TX_FULL_CNT = (TAW+1)'(TX_DEPTH);

  initial begin
    if (RX_DEPTH < 2 || (1 << RAW) != RX_DEPTH || TX_DEPTH < 2 || (1 << TAW) != TX_DEPTH) begin
      $error("queue depths must be powers of two, at least 2");
    end
  end

  // ==========================================================
  // reset release and soft reset
  logic rst_meta_n, rst_n, rxd_meta, rxd_s;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_n <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n <= rst_meta_n;
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxd_meta <= 1'b1;
      rxd_s <= 1'b1;
    end else begin
      rxd_meta <= rxd;
      rxd_s <= rxd_meta;
    end
  end
  logic soft_rst;
  assign soft_rst = chip_reset_in | device_reset_req;

  // ==========================================================
  // avalon slave: one wait cycle, then the access is taken
  logic ack, rd_acc, wr_acc, cmd_wr;
  logic [4:0] cmd;
  assign avs_waitrequest = (avs_read | avs_write) & ~ack;
  assign rd_acc = avs_read & ack;
  assign wr_acc = avs_write & ack;
  assign cmd_wr = wr_acc && avs_address == REG_CMD;
  assign cmd = avs_writedata[CMD_LSB+4:CMD_LSB];

  function automatic logic is_cmd(input logic [4:0] code);
    return cmd_wr && cmd == code;
  endfunction

  // global codes need channel a, otherwise treated as reserved
  logic glob_ok;
  assign glob_ok = is_channel_a;

  // ==========================================================
  // control levels written by commands
  logic [CFG_W-1:0] cfg;
  logic rts_n, tx_en, rx_en;
  assign rx_en = cfg[CFG_RX_EN];
  assign tx_en = cfg[CFG_TX_EN];
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg <= '0;
    end else if (soft_rst || is_cmd(CMD_CLR_REGS)) begin
      cfg <= '0;
    end else if (wr_acc && avs_address == REG_CONFIG) begin
      cfg <= avs_writedata[CFG_W-1:0];
    end else if (is_cmd(CMD_RST_RX)) begin
      cfg[CFG_RX_EN] <= 1'b0;
    end else if (is_cmd(CMD_RST_TX)) begin
      cfg[CFG_TX_EN] <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rts_n <= 1'b1;
      timeout_mode <= 1'b0;
      host_stop <= 1'b0;
      tx_break <= 1'b0;
    end else if (soft_rst) begin
      rts_n <= 1'b1;
      timeout_mode <= 1'b0;
      host_stop <= 1'b0;
      tx_break <= 1'b0;
    end else if (cmd_wr) begin
      unique case (cmd)
        CMD_RTS_ON: rts_n <= 1'b0;
        CMD_RTS_OFF: rts_n <= 1'b1;
        CMD_TMO_ON: timeout_mode <= 1'b1;
        CMD_TMO_OFF: timeout_mode <= 1'b0;
        CMD_HOST_STOP: host_stop <= 1'b1;
        CMD_HOST_RESUME: host_stop <= 1'b0;
        CMD_BRK_START: tx_break <= tx_en;
        CMD_BRK_STOP, CMD_RST_TX: tx_break <= 1'b0;
        default: ;
      endcase
    end
  end
  // pin select in config picks which aux pin carries the handshake
  assign aux_pin_one = cfg[CFG_RTS_SEL] ? rts_n : 1'b1;
  assign aux_pin_two = cfg[CFG_RTS_SEL] ? 1'b1 : rts_n;

  // pending flow characters, dropped by cancel if not yet taken
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      send_resume <= 1'b0;
      send_stop <= 1'b0;
    end else if (soft_rst || is_cmd(CMD_CANCEL_FLOW) || is_cmd(CMD_RST_TX)) begin
      send_resume <= 1'b0;
      send_stop <= 1'b0;
    end else begin
      send_resume <= is_cmd(CMD_SEND_RESUME) | (send_resume & ~tx_flow_taken);
      send_stop <= is_cmd(CMD_SEND_STOP) | (send_stop & ~tx_flow_taken);
    end
  end

  // ==========================================================
  // one-cycle strobes: gang, device reset, address status clear
  logic gwr_resume_arm, gwr_stop_arm, resume_wr, stop_wr;
  logic [7:0] resume_char, stop_char;
  assign resume_wr = wr_acc && avs_address == REG_RESUME;
  assign stop_wr = wr_acc && avs_address == REG_STOP;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      gang_out <= '0;
      device_reset_req <= 1'b0;
      addr_recog_clear <= 1'b0;
      gwr_resume_arm <= 1'b0;
      gwr_stop_arm <= 1'b0;
    end else begin
      device_reset_req <= is_cmd(CMD_RST_DEV) & glob_ok;
      addr_recog_clear <= is_cmd(CMD_RST_ADDR);
      gang_out.load_resume <= is_cmd(CMD_GLD_RESUME) & glob_ok;
      gang_out.load_stop <= is_cmd(CMD_GLD_STOP) & glob_ok;
      gang_out.wr_resume <= resume_wr & gwr_resume_arm;
      gang_out.wr_stop <= stop_wr & gwr_stop_arm;
      gang_out.data <= avs_writedata[7:0];
      if (soft_rst || resume_wr) begin
        gwr_resume_arm <= 1'b0;
      end else if (is_cmd(CMD_GWR_RESUME) && glob_ok) begin
        gwr_resume_arm <= 1'b1;
      end
      if (soft_rst || stop_wr) begin
        gwr_stop_arm <= 1'b0;
      end else if (is_cmd(CMD_GWR_STOP) && glob_ok) begin
        gwr_stop_arm <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      resume_char <= '0;
      stop_char <= '0;
    end else if (soft_rst || is_cmd(CMD_CLR_REGS)) begin
      resume_char <= '0;
      stop_char <= '0;
    end else begin
      if (resume_wr) begin
        resume_char <= avs_writedata[7:0];
      end else if ((is_cmd(CMD_GLD_RESUME) && glob_ok) || gang_in.load_resume) begin
        resume_char <= RESUME_DEFAULT;
      end else if (gang_in.wr_resume) begin
        resume_char <= gang_in.data;
      end
      if (stop_wr) begin
        stop_char <= avs_writedata[7:0];
      end else if ((is_cmd(CMD_GLD_STOP) && glob_ok) || gang_in.load_stop) begin
        stop_char <= STOP_DEFAULT;
      end else if (gang_in.wr_stop) begin
        stop_char <= gang_in.data;
      end
    end
  end

  // ==========================================================
  // receive queue with a one-entry hold for the shift register
  ucc_entry_s rq [RX_DEPTH];
  ucc_entry_s hold, next_hold, q_wd, new_ent;
  logic [RAW-1:0] rwp, rrp;
  logic [RAW:0] rcnt, next_rcnt;
  logic hold_v, next_hold_v, q_we, ovr_ev, pop, push_ev, is_break, brk_inhibit, rx_rst;
  logic rx_full, rx_ready;
  assign rx_rst = soft_rst | is_cmd(CMD_RST_RX);
  assign pop = rd_acc && avs_address == REG_RXDATA && rcnt != '0;
  // only a whole all-zero frame with no stop bit is a break
  assign is_break = rx_char.data == 8'h00 && !rx_char.stop_ok;
  assign push_ev = rx_push & rx_en & ~brk_inhibit;
  assign new_ent.brk = is_break;
  assign new_ent.fe = ~rx_char.stop_ok;
  assign new_ent.pe = cfg[CFG_WAKEUP] ? rx_char.addr_bit : cfg[CFG_PARITY] & ~rx_char.parity_ok;
  assign new_ent.data = rx_char.data;

  always_comb begin
    next_rcnt = rcnt;
    next_hold_v = hold_v;
    next_hold = hold;
    q_we = 1'b0;
    q_wd = hold;
    ovr_ev = 1'b0;
    if (pop) begin
      next_rcnt = rcnt - 1'b1;
    end
    if (hold_v && pop) begin
      q_we = 1'b1;
      next_rcnt = next_rcnt + 1'b1;
      next_hold_v = 1'b0;
    end
    if (push_ev) begin
      if (!q_we && next_rcnt < RX_FULL_CNT) begin
        q_we = 1'b1;
        q_wd = new_ent;
        next_rcnt = next_rcnt + 1'b1;
      end else begin
        ovr_ev = next_hold_v;
        next_hold_v = 1'b1;
        next_hold = new_ent;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (q_we) begin
      rq[rwp] <= q_wd;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rcnt <= '0;
      rwp <= '0;
      rrp <= '0;
      hold_v <= 1'b0;
      hold <= '0;
      rx_full <= 1'b0;
      rx_ready <= 1'b0;
    end else if (rx_rst) begin
      rcnt <= '0;
      rwp <= '0;
      rrp <= '0;
      hold_v <= 1'b0;
      rx_full <= 1'b0;
      rx_ready <= 1'b0;
    end else begin
      rcnt <= next_rcnt;
      rwp <= rwp + RAW'(q_we);
      rrp <= rrp + RAW'(pop);
      hold_v <= next_hold_v;
      hold <= next_hold;
      rx_full <= next_rcnt == RX_FULL_CNT;
      rx_ready <= next_rcnt != '0;
    end
  end

  // break end: two successive 1x edges with the line marking
  logic [1:0] mark_cnt;
  logic brk_end;
  assign brk_end = brk_inhibit && rx_clk1x_edge && rxd_s && mark_cnt == MARK_EDGES - 2'h1;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      brk_inhibit <= 1'b0;
      mark_cnt <= '0;
    end else if (rx_rst) begin
      brk_inhibit <= 1'b0;
      mark_cnt <= '0;
    end else if (push_ev && is_break) begin
      brk_inhibit <= 1'b1;
      mark_cnt <= '0;
    end else if (brk_inhibit && rx_clk1x_edge) begin
      mark_cnt <= rxd_s ? mark_cnt + 2'h1 : 2'h0;
      if (brk_end) begin
        brk_inhibit <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      break_change <= 1'b0;
    end else if (soft_rst) begin
      break_change <= 1'b0;
    end else begin
      break_change <= (break_change & ~is_cmd(CMD_RST_BRKCHG)) | (push_ev & is_break) | brk_end;
    end
  end

  // ==========================================================
  // error accumulation: at head by default, at push in block mode
  logic head_acc;
  logic [3:0] err, err_set;
  always_comb begin
    err_set = {3'b000, ovr_ev};
    if (block_err_mode) begin
      if (q_we) begin
        err_set[3:1] = {q_wd.brk, q_wd.fe, q_wd.pe};
      end
    end else if (rcnt != '0 && !head_acc) begin
      err_set[3:1] = {rq[rrp].brk, rq[rrp].fe, rq[rrp].pe};
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      head_acc <= 1'b0;
      block_err_mode <= 1'b0;
      err <= '0;
    end else if (rx_rst) begin
      head_acc <= 1'b0;
      block_err_mode <= 1'b0;
      err <= '0;
    end else begin
      head_acc <= pop ? 1'b0 : (rcnt != '0);
      block_err_mode <= block_err_mode | is_cmd(CMD_BLOCK_ERR);
      err <= (is_cmd(CMD_RST_ERR) ? 4'h0 : err) | err_set;
    end
  end

  // ==========================================================
  // transmit queue
  logic [7:0] tq [TX_DEPTH];
  logic [TAW-1:0] twp, trp;
  logic [TAW:0] tcnt;
  logic load, take, tx_en_d, tx_ready, tx_empty, tx_rst;
  assign tx_rst = soft_rst | is_cmd(CMD_RST_TX);
  assign load = wr_acc && avs_address == REG_TXDATA && tx_en && tcnt != TX_FULL_CNT;
  assign take = tx_take & tx_char_valid;
  assign tx_char = tq[trp];
  assign tx_char_valid = tcnt != '0 && tx_en && !host_stop && !tx_break;

  always_ff @(posedge ref_clk) begin
    if (load) begin
      tq[twp] <= avs_writedata[7:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tcnt <= '0;
      twp <= '0;
      trp <= '0;
      tx_en_d <= 1'b0;
      tx_ready <= 1'b0;
      tx_empty <= 1'b0;
    end else if (tx_rst || !tx_en) begin
      tcnt <= '0;
      twp <= '0;
      trp <= '0;
      tx_en_d <= 1'b0;
      tx_ready <= 1'b0;
      tx_empty <= 1'b0;
    end else begin
      tcnt <= tcnt + (TAW+1)'(load) - (TAW+1)'(take);
      twp <= twp + TAW'(load);
      trp <= trp + TAW'(take);
      tx_en_d <= 1'b1;
      if (load) begin
        tx_ready <= 1'b0;
      end else if (!tx_en_d || (take && tcnt == (TAW+1)'(1))) begin
        tx_ready <= 1'b1;
      end
      if (load) begin
        tx_empty <= 1'b0;
      end else if (tx_done && tcnt == '0) begin
        tx_empty <= 1'b1;
      end
    end
  end

  // ==========================================================
  // read data
  logic [7:0] status;
  assign status = {err, tx_empty, tx_ready, rx_full, rx_ready};
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack <= 1'b0;
      avs_readdata <= '0;
    end else begin
      ack <= (avs_read | avs_write) & ~ack;
      avs_readdata <= '0;
      if (avs_read && !ack) begin
        unique case (avs_address)
          REG_STATUS: avs_readdata[7:0] <= status;
          REG_RXDATA: avs_readdata[7:0] <= rcnt != '0 ? rq[rrp].data : 8'h00;
          REG_CONFIG: avs_readdata[CFG_W-1:0] <= cfg;
          REG_IFLAGS: avs_readdata[IFLAG_BRK_CHANGE] <= break_change;
          REG_RESUME: avs_readdata[7:0] <= resume_char;
          REG_STOP: avs_readdata[7:0] <= stop_char;
          default: ;
        endcase
      end
    end
  end

  // ==========================================================
  // checks
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_rts_on_cmd: assert property (is_cmd(CMD_RTS_ON) && !soft_rst |=> !rts_n && (aux_pin_one ^ aux_pin_two))
    else $error("request to send not asserted");
  a_timeout_mode: assert property (is_cmd(CMD_TMO_ON) && !soft_rst |=> timeout_mode)
    else $error("time-out mode not set");
  a_foreign_global: assert property (!is_channel_a && !$past(is_channel_a) |-> !device_reset_req && !gang_out.load_resume && !gang_out.load_stop)
    else $error("global command acted outside channel a");
  a_reserved_still: assert property (is_cmd(5'h01) && !soft_rst && !tx_flow_taken |=> $stable(rts_n) && $stable(tx_break) && $stable(send_resume) && $stable(cfg))
    else $error("reserved command changed state");
  a_break_flags: assert property (push_ev && is_break && !rx_rst |=> break_change && brk_inhibit)
    else $error("break did not set change flag");
  a_break_blocks: assert property (brk_inhibit && rx_push |-> !push_ev)
    else $error("entry taken during break");
  a_overrun_set: assert property (push_ev && hold_v && !pop && rcnt == RX_FULL_CNT && !rx_rst |=> err[0])
    else $error("overrun not flagged");
  a_err_clear: assert property (is_cmd(CMD_RST_ERR) && err_set == 4'h0 |=> err == 4'h0)
    else $error("error bits not cleared");
  a_rx_flags: assert property (##1 rx_full == (rcnt == RX_FULL_CNT) && rx_ready == (rcnt != '0))
    else $error("rx flags disagree with fill level");
  a_tx_disabled: assert property (!tx_en |=> !tx_ready && !tx_empty && tcnt == '0)
    else $error("tx flags set while disabled");
  a_gang_load: assert property (is_cmd(CMD_GLD_STOP) && glob_ok && !stop_wr && !soft_rst |=> stop_char == STOP_DEFAULT)
    else $error("gang load value wrong");

  c_break_seen: cover property (push_ev && is_break ##[1:200] brk_end);
  c_overrun: cover property (ovr_ev);
  c_full_two_reads: cover property (rx_full && hold_v && pop ##[1:20] rx_full && pop);
  c_tx_drain: cover property (load ##[1:100] tx_empty);
endmodule

// ===== verilog/ucc_pkg.sv
// package for the uart channel command and status block
// assumes word-addressed register access over an avalon-mm slave
package ucc_pkg;
  // ==========================================================
  // register word indices (byte address is four times these)
  localparam logic [2:0] REG_CMD = 3'h0;
  localparam logic [2:0] REG_STATUS = 3'h1;
  localparam logic [2:0] REG_RXDATA = 3'h2;
  localparam logic [2:0] REG_TXDATA = 3'h3;
  localparam logic [2:0] REG_CONFIG = 3'h4;
  localparam logic [2:0] REG_IFLAGS = 3'h5;
  localparam logic [2:0] REG_RESUME = 3'h6;
  localparam logic [2:0] REG_STOP = 3'h7;
  // ==========================================================
  // command field and codes
  localparam int CMD_LSB = 3;
  localparam logic [4:0] CMD_NOP = 5'h00;
  localparam logic [4:0] CMD_RST_RX = 5'h02;
  localparam logic [4:0] CMD_RST_TX = 5'h03;
  localparam logic [4:0] CMD_RST_ERR = 5'h04;
  localparam logic [4:0] CMD_RST_BRKCHG = 5'h05;
  localparam logic [4:0] CMD_BRK_START = 5'h06;
  localparam logic [4:0] CMD_BRK_STOP = 5'h07;
  localparam logic [4:0] CMD_RTS_ON = 5'h08;
  localparam logic [4:0] CMD_RTS_OFF = 5'h09;
  localparam logic [4:0] CMD_TMO_ON = 5'h0a;
  localparam logic [4:0] CMD_TMO_OFF = 5'h0c;
  localparam logic [4:0] CMD_BLOCK_ERR = 5'h0d;
  localparam logic [4:0] CMD_SEND_RESUME = 5'h10;
  localparam logic [4:0] CMD_SEND_STOP = 5'h11;
  localparam logic [4:0] CMD_GWR_RESUME = 5'h12;
  localparam logic [4:0] CMD_GWR_STOP = 5'h13;
  localparam logic [4:0] CMD_GLD_RESUME = 5'h14;
  localparam logic [4:0] CMD_GLD_STOP = 5'h15;
  localparam logic [4:0] CMD_HOST_RESUME = 5'h16;
  localparam logic [4:0] CMD_HOST_STOP = 5'h17;
  localparam logic [4:0] CMD_CANCEL_FLOW = 5'h18;
  localparam logic [4:0] CMD_RST_ADDR = 5'h1b;
  localparam logic [4:0] CMD_CLR_REGS = 5'h1e;
  localparam logic [4:0] CMD_RST_DEV = 5'h1f;
  // ==========================================================
  // config bits, flag bit, defaults
  localparam int CFG_RX_EN = 0;
  localparam int CFG_TX_EN = 1;
  localparam int CFG_PARITY = 2;
  localparam int CFG_WAKEUP = 3;
  localparam int CFG_RTS_SEL = 4;
  localparam int CFG_W = 5;
  localparam int IFLAG_BRK_CHANGE = 2;
  localparam logic [7:0] RESUME_DEFAULT = 8'h11;
  localparam logic [7:0] STOP_DEFAULT = 8'h13;
  localparam logic [1:0] MARK_EDGES = 2'h2;
  // ==========================================================
  // carriers
  typedef struct packed {
    logic [7:0] data;
    logic stop_ok;
    logic parity_ok;
    logic addr_bit;
  } ucc_rx_char_s;
  typedef struct packed {
    logic brk;
    logic fe;
    logic pe;
    logic [7:0] data;
  } ucc_entry_s;
  typedef struct packed {
    logic load_resume;
    logic load_stop;
    logic wr_resume;
    logic wr_stop;
    logic [7:0] data;
  } ucc_gang_s;
endpackage
